// File: cmd_seq_pkg.sv
`default_nettype none
package cmd_seq_pkg;
  localparam logic [7:0] LISTEN_BASE = 8'h20;
  localparam logic [7:0] UNLISTEN_CODE = 8'h3F;
  localparam logic [7:0] TALK_BASE = 8'h40;
  localparam logic [7:0] UNTALK_CODE = 8'h5F;
  localparam logic [7:0] SECONDARY_BASE = 8'h60;
  localparam logic [7:0] POLL_DISABLE_BASE = 8'h70;
  localparam logic [7:0] SECONDARY_LAST = 8'h7E;
  localparam logic [7:0] POLL_CONFIG_CODE = 8'h05;
  localparam logic [7:0] TAKE_CONTROL_CODE = 8'h09;
  localparam logic [4:0] MAX_ADDR = 5'h1E;
  localparam logic [3:0] AUX_NONE = 4'h0;
  localparam logic [3:0] AUX_TCA = 4'h1;
  localparam logic [3:0] AUX_GTS = 4'h2;
  localparam logic [3:0] AUX_CLEAR_ERR = 4'h3;
  localparam int BURST_MAX = 256;
  localparam logic [8:0] BURST_MAX_W = 9'h100;
  typedef enum logic [1:0] {CTL_IDLE, CTL_ACTIVE, CTL_STANDBY} ctl_state_t;
  typedef enum logic [1:0] {HS_IDLE, HS_WAIT_READY, HS_VALID, HS_RELEASE} hs_state_t;
  typedef enum logic [1:0] {MSG_OTHER, MSG_LISTEN, MSG_TALK, MSG_SECONDARY} msg_kind_t;
endpackage
`default_nettype wire

// File: byte_link_if.sv
`default_nettype none
interface byte_link_if;
  logic start;
  logic [7:0] data;
  logic busy;
  logic done;
  logic noListener;
  modport ctrl (output start, output data, input busy, input done, input noListener);
  modport hs (input start, input data, output busy, output done, output noListener);
endinterface
`default_nettype wire

// File: source_handshake.sv
`default_nettype none
module source_handshake
  import cmd_seq_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  byte_link_if.hs link,
  input wire logic nrfdIn,
  input wire logic ndacIn,
  output logic davOut,
  output logic [7:0] dioOut
);
  hs_state_t state_r, state_nxt;
  logic [7:0] data_r, data_nxt;
  logic done_r, done_nxt;
  logic absent_r, absent_nxt;

  always_comb begin
    state_nxt = state_r;
    data_nxt = data_r;
    done_nxt = 1'b0;
    absent_nxt = 1'b0;
    case (state_r)
      HS_IDLE: begin
        if (link.start) begin
          data_nxt = link.data;
          state_nxt = HS_WAIT_READY;
        end
      end
      HS_WAIT_READY: begin
        // With no acceptor on the cable both lines float false, so the byte can never be taken.
        if (!nrfdIn && !ndacIn) begin
          absent_nxt = 1'b1;
          state_nxt = HS_IDLE;
        end else if (!nrfdIn) begin
          state_nxt = HS_VALID;
        end
      end
      HS_VALID: begin
        if (!ndacIn) begin
          state_nxt = HS_RELEASE;
        end
      end
      HS_RELEASE: begin
        done_nxt = 1'b1;
        state_nxt = HS_IDLE;
      end
      default: state_nxt = HS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= HS_IDLE;
      data_r <= 8'h00;
      done_r <= 1'b0;
      absent_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      data_r <= data_nxt;
      done_r <= done_nxt;
      absent_r <= absent_nxt;
    end
  end

  assign davOut = (state_r == HS_VALID);
  assign dioOut = data_r;
  assign link.busy = (state_r != HS_IDLE);
  assign link.done = done_r;
  assign link.noListener = absent_r;
endmodule
`default_nettype wire

// File: message_decoder.sv
`default_nettype none
module message_decoder
  import cmd_seq_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic valid,
  input wire logic [7:0] msg,
  output logic [1:0] kind,
  output logic [4:0] addr,
  output logic pollEnable,
  output logic pollDisable
);
  logic configSeen_r, configSeen_nxt;
  logic [1:0] kind_r, kind_nxt;
  logic [4:0] addr_r, addr_nxt;
  logic ppe_r, ppe_nxt;
  logic ppd_r, ppd_nxt;

  always_comb begin
    configSeen_nxt = configSeen_r;
    kind_nxt = kind_r;
    addr_nxt = addr_r;
    ppe_nxt = 1'b0;
    ppd_nxt = 1'b0;
    if (valid) begin
      addr_nxt = msg[4:0];
      kind_nxt = MSG_OTHER;
      if (msg[6:5] == LISTEN_BASE[6:5] && msg != UNLISTEN_CODE) begin
        kind_nxt = MSG_LISTEN;
      end else if (msg[6:5] == TALK_BASE[6:5] && msg != UNTALK_CODE) begin
        kind_nxt = MSG_TALK;
      end else if (msg >= SECONDARY_BASE && msg <= SECONDARY_LAST) begin
        kind_nxt = MSG_SECONDARY;
        if (configSeen_r) begin
          ppe_nxt = (msg < POLL_DISABLE_BASE);
          ppd_nxt = (msg >= POLL_DISABLE_BASE);
        end
      end
      if (msg < SECONDARY_BASE) begin
        configSeen_nxt = (msg == POLL_CONFIG_CODE);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      configSeen_r <= 1'b0;
      kind_r <= MSG_OTHER;
      addr_r <= 5'h00;
      ppe_r <= 1'b0;
      ppd_r <= 1'b0;
    end else begin
      configSeen_r <= configSeen_nxt;
      kind_r <= kind_nxt;
      addr_r <= addr_nxt;
      ppe_r <= ppe_nxt;
      ppd_r <= ppd_nxt;
    end
  end

  assign kind = kind_r;
  assign addr = addr_r;
  assign pollEnable = ppe_r;
  assign pollDisable = ppd_r;
endmodule
`default_nettype wire

// File: cmd_sequencer.sv
// Operation
// - Command bytes move only with attention asserted.
// - Listen is 0x20 plus address; 0x3F unlistens.
// - Talk is 0x40 plus address; 0x5F untalks.
// - 0x60-0x7E secondary; after configure, enable/disable.
// - Empty flag shows output register free.
// - No listener sets listener-absent error flag.
// - Take-control command asserts attention, becomes active.
// - Standby command releases attention for talker.
// - Byte-taken flag rises after each data byte.
// - Write: untalk, unlisten, own talk, listener.
// - Take-control byte drops device to idle controller.
`default_nettype none
module cmd_sequencer
  import cmd_seq_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic auxWrite,
  input wire logic [3:0] auxCommand,
  input wire logic byteWrite,
  input wire logic [7:0] byteIn,
  input wire logic nrfdIn,
  input wire logic ndacIn,
  output logic atnOut,
  output logic davOut,
  output logic [7:0] dioOut,
  output logic cmdByteOutEmptyFlag,
  output logic byteTakenFlag,
  output logic listenerAbsentFlag,
  output logic activeController,
  output logic standbyController,
  output logic [7:0] burstCount,
  output logic [1:0] lastKind,
  output logic [4:0] lastAddr,
  output logic pollEnable,
  output logic pollDisable
);
  byte_link_if link ();

  ctl_state_t ctl_r, ctl_nxt;
  logic [7:0] byteOutRegister_r, byteOutRegister_nxt;
  logic pending_r, pending_nxt;
  logic start_r, start_nxt;
  logic inFlightIsCmd_r, inFlightIsCmd_nxt;
  logic inFlightTct_r, inFlightTct_nxt;
  logic empty_r, empty_nxt;
  logic taken_r, taken_nxt;
  logic absent_r, absent_nxt;
  logic [8:0] burst_r, burst_nxt;
  logic atn_r, atn_nxt;
  logic decodeValid_r, decodeValid_nxt;
  logic activeCtl_r, activeCtl_nxt;
  logic standbyCtl_r, standbyCtl_nxt;
  logic davWire;
  logic [7:0] dioWire;
  logic dav_r;
  logic [7:0] dio_r;

  source_handshake u_handshake (
    .core_clk(core_clk),
    .rst(rst),
    .link(link.hs),
    .nrfdIn(nrfdIn),
    .ndacIn(ndacIn),
    .davOut(davWire),
    .dioOut(dioWire)
  );

  message_decoder u_decoder (
    .core_clk(core_clk),
    .rst(rst),
    .valid(decodeValid_r),
    .msg(byteOutRegister_r),
    .kind(lastKind),
    .addr(lastAddr),
    .pollEnable(pollEnable),
    .pollDisable(pollDisable)
  );

  assign link.start = start_r;
  assign link.data = byteOutRegister_r;

  always_comb begin
    ctl_nxt = ctl_r;
    byteOutRegister_nxt = byteOutRegister_r;
    pending_nxt = pending_r;
    start_nxt = 1'b0;
    inFlightIsCmd_nxt = inFlightIsCmd_r;
    inFlightTct_nxt = inFlightTct_r;
    empty_nxt = empty_r;
    taken_nxt = taken_r;
    absent_nxt = absent_r;
    burst_nxt = burst_r;
    decodeValid_nxt = 1'b0;
    if (auxWrite) begin
      case (auxCommand)
        AUX_TCA: begin
          ctl_nxt = CTL_ACTIVE;
          burst_nxt = 9'h000;
        end
        AUX_GTS: begin
          if (ctl_r == CTL_ACTIVE) begin
            ctl_nxt = CTL_STANDBY;
          end
        end
        AUX_CLEAR_ERR: absent_nxt = 1'b0;
        default: ctl_nxt = ctl_r;
      endcase
    end
    // The host only writes while the register is free; a write when busy is dropped to keep order.
    if (byteWrite && empty_r) begin
      byteOutRegister_nxt = byteIn;
      pending_nxt = 1'b1;
      empty_nxt = 1'b0;
      taken_nxt = 1'b0;
    end
    // Launch a queued byte; commands wait for attention, data waits for standby.
    if (pending_r && !link.busy && !start_r) begin
      if (ctl_r == CTL_ACTIVE && atn_r) begin
        start_nxt = 1'b1;
        pending_nxt = 1'b0;
        inFlightIsCmd_nxt = 1'b1;
        inFlightTct_nxt = (byteOutRegister_r == TAKE_CONTROL_CODE);
        decodeValid_nxt = 1'b1;
        if (burst_r != BURST_MAX_W) begin
          burst_nxt = burst_r + 9'h001;
        end
      end else if (ctl_r == CTL_STANDBY && !atn_r) begin
        start_nxt = 1'b1;
        pending_nxt = 1'b0;
        inFlightIsCmd_nxt = 1'b0;
        inFlightTct_nxt = 1'b0;
      end
    end
    if (link.done) begin
      empty_nxt = 1'b1;
      if (!inFlightIsCmd_r) begin
        taken_nxt = 1'b1;
      end
      if (inFlightIsCmd_r && inFlightTct_r) begin
        ctl_nxt = CTL_IDLE;
      end
    end
    if (link.noListener) begin
      absent_nxt = 1'b1;
      empty_nxt = 1'b1;
    end
  end

  always_comb begin
    atn_nxt = (ctl_nxt == CTL_ACTIVE);
    activeCtl_nxt = (ctl_nxt == CTL_ACTIVE);
    standbyCtl_nxt = (ctl_nxt == CTL_STANDBY);
    // Attention must not drop from launch until a command byte is taken, or it would go out as data.
    if ((link.busy || start_r || start_nxt) && inFlightIsCmd_nxt && ctl_nxt != CTL_IDLE) begin
      atn_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctl_r <= CTL_IDLE;
      byteOutRegister_r <= 8'h00;
      pending_r <= 1'b0;
      start_r <= 1'b0;
      inFlightIsCmd_r <= 1'b0;
      inFlightTct_r <= 1'b0;
      empty_r <= 1'b1;
      taken_r <= 1'b0;
      absent_r <= 1'b0;
      burst_r <= 9'h000;
      atn_r <= 1'b0;
      decodeValid_r <= 1'b0;
      activeCtl_r <= 1'b0;
      standbyCtl_r <= 1'b0;
      dav_r <= 1'b0;
      dio_r <= 8'h00;
    end else begin
      ctl_r <= ctl_nxt;
      byteOutRegister_r <= byteOutRegister_nxt;
      pending_r <= pending_nxt;
      start_r <= start_nxt;
      inFlightIsCmd_r <= inFlightIsCmd_nxt;
      inFlightTct_r <= inFlightTct_nxt;
      empty_r <= empty_nxt;
      taken_r <= taken_nxt;
      absent_r <= absent_nxt;
      burst_r <= burst_nxt;
      atn_r <= atn_nxt;
      decodeValid_r <= decodeValid_nxt;
      activeCtl_r <= activeCtl_nxt;
      standbyCtl_r <= standbyCtl_nxt;
      dav_r <= davWire;
      dio_r <= dioWire;
    end
  end

  assign atnOut = atn_r;
  assign davOut = dav_r;
  assign dioOut = dio_r;
  assign cmdByteOutEmptyFlag = empty_r;
  assign byteTakenFlag = taken_r;
  assign listenerAbsentFlag = absent_r;
  assign activeController = activeCtl_r;
  assign standbyController = standbyCtl_r;
  assign burstCount = burst_r[7:0];

  AST_TCA_ACTIVE: assert property (@(posedge core_clk) disable iff (rst)
    auxWrite && auxCommand == AUX_TCA && !link.done |=> atnOut)
    else $error("Take control did not raise attention.");

  AST_GTS_RELEASE: assert property (@(posedge core_clk) disable iff (rst)
    auxWrite && auxCommand == AUX_GTS && ctl_r == CTL_ACTIVE && !link.busy && !start_r && !pending_r
      |=> ##1 !atnOut)
    else $error("Standby did not release attention.");

  AST_CMD_UNDER_ATN: assert property (@(posedge core_clk) disable iff (rst)
    davOut && inFlightIsCmd_r |-> atnOut)
    else $error("Command byte launched without attention.");

  AST_EMPTY_CLEARS: assert property (@(posedge core_clk) disable iff (rst)
    byteWrite && empty_r |=> !cmdByteOutEmptyFlag)
    else $error("Empty flag stayed set after a write.");

  AST_ABSENT_SET: assert property (@(posedge core_clk) disable iff (rst)
    link.noListener |=> listenerAbsentFlag && cmdByteOutEmptyFlag)
    else $error("Missing listener not flagged.");

  AST_TAKEN_DATA: assert property (@(posedge core_clk) disable iff (rst)
    link.done && !inFlightIsCmd_r |=> byteTakenFlag)
    else $error("Byte-taken flag not raised after data byte.");

  AST_TCT_IDLE: assert property (@(posedge core_clk) disable iff (rst)
    link.done && inFlightIsCmd_r && inFlightTct_r |=> ##1 !atnOut && !activeController)
    else $error("Take control byte did not drop to idle.");

  AST_WRITE_ONE_CYCLE: assert property (@(posedge core_clk) disable iff (rst)
    byteWrite && empty_r |=> byteOutRegister_r == $past(byteIn))
    else $error("Byte write not stored in one cycle.");

  AST_LISTEN_DECODE: assert property (@(posedge core_clk) disable iff (rst)
    decodeValid_r && byteOutRegister_r[7:5] == 3'h1 && byteOutRegister_r != UNLISTEN_CODE
      |=> lastKind == MSG_LISTEN)
    else $error("Listen address misdecoded.");

  AST_RESET_STATE: assert property (@(posedge core_clk) rst |=> !atnOut && !davOut && cmdByteOutEmptyFlag
    && !listenerAbsentFlag && !byteTakenFlag && !activeController && !standbyController)
    else $error("Outputs not at reset values.");

  AST_EMPTY_HOLDS: assert property (@(posedge core_clk) disable iff (rst)
    !cmdByteOutEmptyFlag && !link.done && !link.noListener |=> !cmdByteOutEmptyFlag)
    else $error("Empty flag set before the byte was taken.");

  AST_DONE_SETS_EMPTY: assert property (@(posedge core_clk) disable iff (rst)
    link.done |=> cmdByteOutEmptyFlag)
    else $error("Empty flag not set after the byte was taken.");

  AST_TAKEN_CLEARS: assert property (@(posedge core_clk) disable iff (rst)
    byteWrite && cmdByteOutEmptyFlag |=> !byteTakenFlag)
    else $error("Byte-taken flag not cleared by a new write.");

  AST_ABSENT_STICKY: assert property (@(posedge core_clk) disable iff (rst)
    listenerAbsentFlag && !(auxWrite && auxCommand == AUX_CLEAR_ERR) |=> listenerAbsentFlag)
    else $error("Listener-absent flag cleared without a clear command.");

  AST_TALK_DECODE: assert property (@(posedge core_clk) disable iff (rst)
    decodeValid_r && byteOutRegister_r >= TALK_BASE && byteOutRegister_r < UNTALK_CODE
      |=> lastKind == MSG_TALK && lastAddr == byteOutRegister_r[4:0])
    else $error("Talk address misdecoded.");

  AST_UNTALK_DECODE: assert property (@(posedge core_clk) disable iff (rst)
    decodeValid_r && byteOutRegister_r == UNTALK_CODE |=> lastKind == MSG_OTHER)
    else $error("Untalk taken as an address.");

  AST_UNLISTEN_DECODE: assert property (@(posedge core_clk) disable iff (rst)
    decodeValid_r && byteOutRegister_r == UNLISTEN_CODE |=> lastKind == MSG_OTHER)
    else $error("Unlisten taken as an address.");

  AST_SECONDARY_KIND: assert property (@(posedge core_clk) disable iff (rst)
    decodeValid_r && byteOutRegister_r >= SECONDARY_BASE && byteOutRegister_r <= SECONDARY_LAST
      |=> lastKind == MSG_SECONDARY)
    else $error("Secondary address misdecoded.");

  AST_NO_ENABLE_HIGH: assert property (@(posedge core_clk) disable iff (rst)
    decodeValid_r && byteOutRegister_r >= POLL_DISABLE_BASE |=> !pollEnable)
    else $error("Poll enable raised by a high code.");

  AST_NO_DISABLE_LOW: assert property (@(posedge core_clk) disable iff (rst)
    decodeValid_r && byteOutRegister_r < POLL_DISABLE_BASE |=> !pollDisable)
    else $error("Poll disable raised by a low code.");

  AST_POLL_SECONDARY: assert property (@(posedge core_clk) disable iff (rst)
    pollEnable || pollDisable |-> lastKind == MSG_SECONDARY)
    else $error("Poll pulse without a secondary address.");

  AST_CMD_FROM_ACTIVE: assert property (@(posedge core_clk) disable iff (rst)
    start_r && inFlightIsCmd_r |-> $past(ctl_r) == CTL_ACTIVE)
    else $error("Command byte launched while not active.");

  AST_DATA_FROM_STANDBY: assert property (@(posedge core_clk) disable iff (rst)
    start_r && !inFlightIsCmd_r |-> $past(ctl_r) == CTL_STANDBY && !$past(atn_r))
    else $error("Data byte launched outside standby.");

  AST_ONE_IN_FLIGHT: assert property (@(posedge core_clk) disable iff (rst)
    start_r |-> !link.busy)
    else $error("Byte launched while another was in flight.");
endmodule
`default_nettype wire

// File: cable_listener_model.sv
`default_nettype none
module cable_listener_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic present,
  input wire logic atnOut,
  input wire logic davOut,
  input wire logic [7:0] dioOut,
  output logic nrfdIn,
  output logic ndacIn,
  output logic capEv,
  output logic [7:0] capByte,
  output logic capAtn
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // Acceptance waits a random 0 to 3 cycles so that both prompt and slow listeners are seen.
  always @(posedge core_clk) begin
    capEv <= 1'b0;
    if (rst || !present) begin
      nrfdIn <= 1'b0;
      ndacIn <= present;
      cnt <= 0;
    end else if (davOut && ndacIn) begin
      if (cnt == 0) begin
        ndacIn <= 1'b0;
        nrfdIn <= 1'b1;
        capEv <= 1'b1;
        capByte <= dioOut;
        capAtn <= atnOut;
        cnt <= $urandom_range(3, 0);
      end else begin
        cnt <= cnt - 1;
      end
    end else if (!davOut && !ndacIn) begin
      ndacIn <= 1'b1;
      nrfdIn <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: tb_ieee488_controller_command_sequencer.sv
`default_nettype none
`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin miscompares++; $display("ERROR %0t value mismatch", $time); end end
module tb_ieee488_controller_command_sequencer;
  import cmd_seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic auxWrite = 1'b0;
  logic [3:0] auxCommand = 4'h0;
  logic byteWrite = 1'b0;
  logic [7:0] byteIn = 8'h00;
  logic present = 1'b1;
  logic nrfdIn, ndacIn, atnOut, davOut, capEv, capAtn;
  logic [7:0] dioOut, capByte, burstCount;
  logic cmdByteOutEmptyFlag, byteTakenFlag, listenerAbsentFlag, activeController, standbyController;
  logic [1:0] lastKind;
  logic [4:0] lastAddr, own, lst;
  logic pollEnable, pollDisable;
  int miscompares = 0;
  int totalChecks = 0;
  int enCnt = 0;
  int disCnt = 0;
  logic [8:0] q[$];
  logic [8:0] e;
  cmd_sequencer dut_u (.core_clk(core_clk), .rst(rst), .auxWrite(auxWrite), .auxCommand(auxCommand),
    .byteWrite(byteWrite), .byteIn(byteIn), .nrfdIn(nrfdIn), .ndacIn(ndacIn), .atnOut(atnOut),
    .davOut(davOut), .dioOut(dioOut), .cmdByteOutEmptyFlag(cmdByteOutEmptyFlag),
    .byteTakenFlag(byteTakenFlag), .listenerAbsentFlag(listenerAbsentFlag),
    .activeController(activeController), .standbyController(standbyController),
    .burstCount(burstCount), .lastKind(lastKind), .lastAddr(lastAddr), .pollEnable(pollEnable),
    .pollDisable(pollDisable));
  cable_listener_model far_u (.core_clk(core_clk), .rst(rst), .present(present), .atnOut(atnOut),
    .davOut(davOut), .dioOut(dioOut), .nrfdIn(nrfdIn), .ndacIn(ndacIn), .capEv(capEv),
    .capByte(capByte), .capAtn(capAtn));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic stop_test();
    if (miscompares == 0 && totalChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic aux(input logic [3:0] c);
    @(posedge core_clk) begin auxWrite <= 1'b1; auxCommand <= c; end
    @(posedge core_clk) auxWrite <= 1'b0;
    @(posedge core_clk) #1;
  endtask
  // A second write while the register is busy must vanish, so the queue never sees it.
  task automatic sendB(input logic [7:0] b, input logic a, input bit push, input bit dup);
    for (int i = 0; i < 200 && cmdByteOutEmptyFlag !== 1'b1; i++) @(posedge core_clk) #1;
    @(posedge core_clk) begin byteWrite <= 1'b1; byteIn <= b; end
    if (push) q.push_back({b, a});
    @(posedge core_clk) byteWrite <= 1'b0;
    if (dup) begin
      @(posedge core_clk) begin byteWrite <= 1'b1; byteIn <= ~b; end
      @(posedge core_clk) byteWrite <= 1'b0;
    end
    @(posedge core_clk) #1;
    for (int i = 0; i < 200 && cmdByteOutEmptyFlag !== 1'b1; i++) @(posedge core_clk) #1;
    `CHK(cmdByteOutEmptyFlag, 1'b1)
  endtask
  always @(posedge core_clk) begin
    if (pollEnable === 1'b1) enCnt++;
    if (pollDisable === 1'b1) disCnt++;
    if (capEv === 1'b1) begin
      if (q.size() == 0) begin
        `CHK(1'b0, 1'b1)
      end else begin
        e = q.pop_front();
        `CHK(capByte, e[8:1])
        `CHK(capAtn, e[0])
      end
    end
  end
  initial begin
    #300000;
    miscompares++;
    stop_test();
  end
  initial begin
    void'($urandom(86));
    own = 5'($urandom_range(30, 0));
    lst = 5'($urandom_range(30, 0));
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk) #1;
    `CHK({atnOut, davOut, cmdByteOutEmptyFlag, listenerAbsentFlag, activeController}, 5'h04)
    @(posedge core_clk) begin auxWrite <= 1'b1; auxCommand <= AUX_TCA; end
    @(posedge core_clk) auxWrite <= 1'b0;
    @(posedge core_clk) #1;
    `CHK(atnOut, 1'b1)
    @(posedge core_clk) #1;
    `CHK({atnOut, activeController}, 2'h3)
    sendB(UNTALK_CODE, 1'b1, 1, 1);
    sendB(UNLISTEN_CODE, 1'b1, 1, 0);
    sendB(TALK_BASE + {3'h0, own}, 1'b1, 1, 0);
    `CHK({lastKind, lastAddr}, {MSG_TALK, own})
    sendB(LISTEN_BASE + {3'h0, lst}, 1'b1, 1, 1);
    `CHK({lastKind, lastAddr}, {MSG_LISTEN, lst})
    `CHK(burstCount, 8'h04)
    aux(AUX_GTS);
    @(posedge core_clk) #1;
    `CHK({atnOut, standbyController}, 2'h1)
    for (int i = 0; i < 3; i++) begin
      sendB(8'($urandom), 1'b0, 1, 0);
      `CHK(byteTakenFlag, 1'b1)
    end
    aux(AUX_TCA);
    @(posedge core_clk) #1;
    `CHK({atnOut, activeController}, 2'h3)
    sendB(UNTALK_CODE, 1'b1, 1, 0);
    `CHK(byteTakenFlag, 1'b0)
    sendB(UNLISTEN_CODE, 1'b1, 1, 0);
    `CHK(lastKind, MSG_OTHER)
    sendB(POLL_CONFIG_CODE, 1'b1, 1, 0);
    sendB(SECONDARY_BASE + 8'($urandom_range(15, 0)), 1'b1, 1, 0);
    `CHK(lastKind, MSG_SECONDARY)
    sendB(POLL_DISABLE_BASE + 8'($urandom_range(14, 0)), 1'b1, 1, 0);
    `CHK({enCnt, disCnt}, {32'd1, 32'd1})
    present <= 1'b0;
    sendB(UNTALK_CODE, 1'b1, 0, 0);
    `CHK(listenerAbsentFlag, 1'b1)
    present <= 1'b1;
    aux(AUX_CLEAR_ERR);
    `CHK(listenerAbsentFlag, 1'b0)
    sendB(UNTALK_CODE, 1'b1, 1, 0);
    sendB(UNLISTEN_CODE, 1'b1, 1, 0);
    sendB(TALK_BASE + {3'h0, lst}, 1'b1, 1, 0);
    sendB(TAKE_CONTROL_CODE, 1'b1, 1, 0);
    repeat (2) @(posedge core_clk);
    #1;
    `CHK({atnOut, activeController}, 2'h0)
    `CHK(q.size(), 0)
    stop_test();
  end
endmodule
`default_nettype wire
